// File: rtl/cps_pkg.sv
// Constants, types and state layout of the power-path sequencer.
// Assumes a single 10 MHz clock and comparator levels from the analog die.
package cps_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ    = 10000;
  localparam int DETECT_MS  = 700;
  localparam int INRUSH_MS  = 10;
  localparam int STEP_MS    = 1;
  localparam int DEAD_US    = 10;
  localparam int SW_KHZ     = 300;
  localparam int REFRESH_NS = 80;
  localparam int DEAD_CYC   = (DEAD_US * CLK_KHZ + 999) / 1000;
  localparam int PWM_PERIOD = CLK_KHZ / SW_KHZ;
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_KHZ + 999999) / 1000000;
  localparam int BOOT_LIMIT = 3;
  localparam int SS_STEPS   = 8;
  localparam int SS_SHIFT   = 3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] RST_TARGET = 8'h00;
  localparam logic [7:0] RST_DUTY   = 8'h00;

  typedef struct packed {
    logic supply_ok;    // Supply above 4 V
    logic sense_bias;   // Adapter sense above 0.6 V
    logic sense_valid;  // Adapter sense above 2.4 V
    logic node_185;     // Adapter node above pack + 185 mV
    logic node_285;     // Adapter node above pack + 285 mV
    logic ovp;          // Overvoltage threshold input above 3.1 V
    logic hot_shut;     // Thermal shutdown
    logic therm_ok;     // Thermistor in window
    logic ref_ok;       // Ratio reference above 2.4 V
    logic cell_low;     // Pack below 2.9 V per cell
    logic boot_low;     // Bootstrap minus switch node below 4 V
    logic chg_en_n;     // Host charge enable, active low
    logic learn;        // Host learn request
  } cps_cmp_s;

  typedef enum logic [1:0] {
    SEL_PACK    = 2'b00,
    SEL_TO_AD   = 2'b01,
    SEL_ADAPTER = 2'b10,
    SEL_TO_PACK = 2'b11
  } cps_sel_e;

  typedef struct packed {
    cps_cmp_s    sync1;
    cps_cmp_s    sync2;
    logic [22:0] det_cnt;
    cps_sel_e    sel;
    logic [7:0]  dead;
    logic        pack_on;
    logic        ad_on;
    logic        bias_partial;
    logic        bias_full;
    logic        gate_reg;
    logic        imon_en;
    logic        good;
    logic        charging;
    logic [3:0]  step;
    logic [13:0] step_cnt;
    logic [7:0]  target;
    logic [5:0]  pwm_cnt;
    logic [1:0]  boot_cnt;
    logic [3:0]  refresh;
    logic        hs;
    logic        ls;
    logic [7:0]  prog;
    logic [7:0]  duty;
    logic        ack;
    logic [31:0] rdat;
  } cps_state_s;

endpackage : cps_pkg

// File: rtl/cps_sequencer.sv
// Charger power-path sequencer: detection, selector, soft start, PWM.
// Assumes comparator levels arrive asynchronously and a Wishbone master.
//
// Behaviour
// - Before adapter detection, pack switch on and adapter switch off.
// - Supply below 4 V keeps every function disabled.
// - Sense below 0.6 V: partial bias, drives only, current monitor grounded.
// - Sense above 0.6 V: full bias, reference, regulator when enabled.
// - Sense above 2.4 V for 700 ms raises adapter good.
// - Charging only when every qualification condition holds.
// - Pack disconnected before adapter connected; never both on.
// - Changeover after 700 ms and only with 285 mV headroom.
// - Both switches off 10 us before adapter switch turns on.
// - Adapter state: pack drive off, adapter drive on.
// - Removal waits for headroom loss, then 10 us dead time.
// - Learn low: default adapter-dependent selector states.
// - Learn high stops charging and, unless the pack is below 2.9 V per cell, forces pack on, adapter off.
// - Learn with pack below 2.9 V per cell reconnects the adapter.
// - Charge target ramps in 8 equal steps of 1 ms.
// - Buck switches at a fixed 303 kHz (33 clock cycles per period).
// - Duty from zero up to full-on requests.
// - Bootstrap low at 4 consecutive switching period ends forces a low-side refresh pulse.
// - Overvoltage disables charge, selects pack, not latched.
// - Pack recovery during learn reconnects the pack.
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int DETECT_CYC = DETECT_MS * CLK_KHZ,
  parameter int INRUSH_CYC = INRUSH_MS * CLK_KHZ,
  parameter int STEP_CYC   = STEP_MS * CLK_KHZ
) (
  input  wire logic          clk_i,       // 10 MHz clock
  input  wire logic          rst_i,       // Sync reset, high
  input  wire cps_pkg::cps_cmp_s cmp_i,   // Async comparator levels
  input  wire logic          wb_cyc_i,    // Bus cycle
  input  wire logic          wb_stb_i,    // Bus strobe
  input  wire logic          wb_we_i,     // Write enable
  input  wire logic [7:0]    wb_adr_i,    // Byte address
  input  wire logic [3:0]    wb_sel_i,    // Byte enables
  input  wire logic [31:0]   wb_dat_i,    // Write data
  output logic [31:0]        wb_dat_o,    // Read data
  output logic               wb_ack_o,    // Acknowledge
  output logic               pack_gate_drive_o,    // Pack switch on
  output logic               adapter_gate_drive_o, // Adapter switch on
  output logic               bias_partial_o,       // Crude bias up
  output logic               bias_full_o,          // Full bias, reference
  output logic               gate_driver_reg_o,    // Regulator on
  output logic               input_current_mon_o,  // Monitor valid
  output logic               adapter_good_o,       // Adapter good
  output logic               charge_en_o,          // Charging active
  output logic [7:0]         charge_target_o,      // Soft-start target
  output logic               high_side_o,          // High-side gate
  output logic               low_side_o            // Low-side gate
);
  import cps_pkg::*;

  // ---------------------------------------------------------------
  // Derived constants
  // ---------------------------------------------------------------
  localparam logic [22:0] DET_LIM  = 23'(DETECT_CYC);
  localparam logic [22:0] QUAL_LIM = 23'(DETECT_CYC + INRUSH_CYC);
  localparam logic [7:0]  DEAD_LAST = 8'(DEAD_CYC - 1);
  localparam logic [13:0] STEP_LAST = 14'(STEP_CYC - 1);
  localparam logic [5:0]  PWM_LAST  = 6'(PWM_PERIOD - 1);
  localparam logic [7:0]  PWM_FULL  = 8'(PWM_PERIOD);
  localparam logic [3:0]  REF_LEN   = 4'(REFRESH_CYC);
  localparam logic [1:0]  BOOT_LAST = 2'(BOOT_LIMIT);
  localparam logic [3:0]  STEP_TOP  = 4'(SS_STEPS);
  localparam int          OVP_BOUND = 4;

  cps_state_s  s;
  cps_state_s  n;
  cps_cmp_s    c;
  logic        powered;
  logic        sensed;
  logic        valid;
  logic        det_done;
  logic        qual_done;
  logic        learn_hold;
  logic        to_adapter;
  logic        leave_ad;
  logic        chg_ok;
  logic        wrap;
  logic        bus_req;
  logic [11:0] prod;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    // Second stage alone reads the first stage
    n.sync1 = cmp_i;
    n.sync2 = s.sync1;
    c = s.sync2;
    powered = c.supply_ok;
    sensed = powered && c.sense_bias;
    valid = sensed && c.sense_valid;
    det_done = s.det_cnt >= DET_LIM;
    qual_done = s.det_cnt >= QUAL_LIM;

    // Detection timer restarts whenever the adapter looks invalid
    if (!valid) begin
      n.det_cnt = '0;
    end else if (!qual_done) begin
      n.det_cnt = s.det_cnt + 23'h000001;
    end

    // Learn holds the pack unless the pack is depleted
    learn_hold = c.learn && !c.cell_low;
    to_adapter = det_done && c.node_285 && !c.ovp
                 && !learn_hold;
    leave_ad = c.ovp || learn_hold
               || (!det_done && !c.node_285);

    unique case (s.sel)
      SEL_PACK: begin
        if (to_adapter) begin
          n.sel = SEL_TO_AD;
          n.dead = '0;
        end
      end
      SEL_TO_AD: begin
        if (!to_adapter) begin
          n.sel = SEL_PACK;
        end else if (s.dead == DEAD_LAST) begin
          n.sel = SEL_ADAPTER;
        end else begin
          n.dead = s.dead + 8'h01;
        end
      end
      SEL_ADAPTER: begin
        if (leave_ad) begin
          n.sel = SEL_TO_PACK;
          n.dead = '0;
        end
      end
      SEL_TO_PACK: begin
        if (s.dead == DEAD_LAST) begin
          n.sel = SEL_PACK;
        end else begin
          n.dead = s.dead + 8'h01;
        end
      end
    endcase
    if (!powered) begin
      n.sel = SEL_PACK;
      n.dead = '0;
    end

    // Gate drives decode the next selector state, both held off without supply
    n.pack_on = powered && (n.sel == SEL_PACK);
    n.ad_on = powered && (n.sel == SEL_ADAPTER);

    // Bias tiers
    n.bias_partial = powered;
    n.bias_full = sensed;
    n.gate_reg = sensed && !c.chg_en_n;
    n.imon_en = sensed;
    n.good = valid && det_done;

    // Charge qualification
    chg_ok = !c.chg_en_n && powered && valid && c.node_185
             && !c.ovp && qual_done && !c.hot_shut && c.therm_ok
             && c.ref_ok && !c.learn;

    // Soft start restarts on every enable
    if (!chg_ok) begin
      n.charging = 1'b0;
      n.step = '0;
      n.step_cnt = '0;
    end else if (!s.charging) begin
      n.charging = 1'b1;
      n.step = 4'h1;
      n.step_cnt = '0;
    end else if (s.step != STEP_TOP) begin
      if (s.step_cnt == STEP_LAST) begin
        n.step = s.step + 4'h1;
        n.step_cnt = '0;
      end else begin
        n.step_cnt = s.step_cnt + 14'h0001;
      end
    end
    prod = {4'h0, s.prog} * {8'h00, n.step};
    n.target = prod[SS_SHIFT +: 8];

    // PWM runs only while charging; counter gives the fixed rate
    wrap = s.pwm_cnt == PWM_LAST;
    if (!n.charging) begin
      n.pwm_cnt = '0;
      n.boot_cnt = '0;
      n.refresh = '0;
      n.hs = 1'b0;
      n.ls = 1'b0;
    end else begin
      n.pwm_cnt = wrap ? 6'h00 : s.pwm_cnt + 6'h01;
      if (s.refresh != 4'h0) begin
        n.refresh = s.refresh - 4'h1;
      end
      if (wrap) begin
        if (!c.boot_low) begin
          n.boot_cnt = '0;
        end else if (s.boot_cnt == BOOT_LAST) begin
          n.boot_cnt = '0;
          n.refresh = REF_LEN;
        end else begin
          n.boot_cnt = s.boot_cnt + 2'h1;
        end
      end
      // Full-on when the request reaches the period
      n.hs = (s.duty >= PWM_FULL)
             || ({2'b00, n.pwm_cnt} < s.duty);
      if (n.refresh != 4'h0) begin
        n.hs = 1'b0;
      end
      n.ls = !n.hs;
    end

    // Wishbone slave, one wait state, ack dropped after one cycle
    bus_req = wb_cyc_i && wb_stb_i && !s.ack;
    n.ack = bus_req;
    n.rdat = '0;
    if (bus_req) begin
      if (wb_adr_i == ADR_CTRL) begin
        n.rdat = {16'h0000, s.duty, s.prog};
        if (wb_we_i && wb_sel_i[0]) begin
          n.prog = wb_dat_i[7:0];
        end
        if (wb_we_i && wb_sel_i[1]) begin
          n.duty = wb_dat_i[15:8];
        end
      end else if (wb_adr_i == ADR_STATUS) begin
        n.rdat = {16'h0000, s.target, s.step, s.sel,
                  s.good, s.charging};
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.prog <= RST_TARGET;
      s.duty <= RST_DUTY;
      s.sel <= SEL_PACK;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o             = s.rdat;
  assign wb_ack_o             = s.ack;
  assign pack_gate_drive_o    = s.pack_on;
  assign adapter_gate_drive_o = s.ad_on;
  assign bias_partial_o       = s.bias_partial;
  assign bias_full_o          = s.bias_full;
  assign gate_driver_reg_o    = s.gate_reg;
  assign input_current_mon_o  = s.imon_en;
  assign adapter_good_o       = s.good;
  assign charge_en_o          = s.charging;
  assign charge_target_o      = s.target;
  assign high_side_o          = s.hs;
  assign low_side_o           = s.ls;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_both_off;
    (!s.ad_on) [*8];
  endsequence

  // Supply loss may end the dead time early, so only conduction is checked
  sequence seq_back_to_pack;
    (!s.pack_on && !s.ad_on) [*8];
  endsequence

  chk_never_both_on : assert property (
    !(s.pack_on && s.ad_on))
    else $error("both switches on");

  chk_dead_to_ad : assert property (
    ($fell(s.pack_on) && s.sel == SEL_TO_AD) |-> seq_both_off)
    else $error("dead time before adapter too short");

  chk_dead_to_pack : assert property (
    ($fell(s.ad_on) && s.sel == SEL_TO_PACK) |-> seq_back_to_pack)
    else $error("dead time before pack too short");

  chk_unpowered_off : assert property (
    !s.sync2.supply_ok |=> !s.pack_on && !s.ad_on && !s.bias_partial
                           && !s.charging)
    else $error("active without supply");

  chk_monitor_ground : assert property (
    !s.sync2.sense_bias |=> !input_current_mon_o && !gate_driver_reg_o)
    else $error("monitor active below sense threshold");

  chk_good_delay : assert property (
    $rose(adapter_good_o) |-> s.det_cnt > DET_LIM)
    else $error("adapter good before delay");

  chk_learn_stop : assert property (
    (s.sync2.learn && !s.sync2.cell_low) |=> !charge_en_o
      ##0 (s.sel != SEL_ADAPTER || s.ad_on == $past(s.ad_on)))
    else $error("charging during learn");

  chk_ovp_release : assert property (
    s.sync2.ovp [*2] |-> ##[1:OVP_BOUND] (!charge_en_o
                                         && s.sel != SEL_TO_AD))
    else $error("overvoltage did not stop charging");

  chk_soft_first : assert property (
    $rose(charge_en_o) |-> s.step == 4'h1 ##1 s.step == 4'h1)
    else $error("soft start not from first step");

  chk_refresh_hs : assert property (
    (s.refresh != 4'h0) |-> !high_side_o && low_side_o)
    else $error("high side on during refresh");

  chk_ack_pulse : assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  chk_bias_partial : assert property (
    s.sync2.supply_ok |=> bias_partial_o)
    else $error("partial bias missing with supply");

  chk_bias_full : assert property (
    (s.sync2.supply_ok && s.sync2.sense_bias) |=> bias_full_o
      && input_current_mon_o)
    else $error("full bias missing above sense threshold");

  chk_reg_bias : assert property (
    gate_driver_reg_o |-> bias_full_o)
    else $error("regulator on without full bias");

  chk_adapter_drive : assert property (
    (s.sel == SEL_ADAPTER) |-> adapter_gate_drive_o && !pack_gate_drive_o)
    else $error("adapter state drives wrong");

  chk_pack_default : assert property (
    (s.sel == SEL_PACK && bias_partial_o) |-> pack_gate_drive_o)
    else $error("pack switch off in pack state");

  chk_pwm_idle : assert property (
    !charge_en_o |-> !high_side_o && !low_side_o)
    else $error("converter switching while not charging");

  chk_pwm_period : assert property (
    s.pwm_cnt <= PWM_LAST)
    else $error("switching counter beyond period");

  chk_gate_excl : assert property (
    !(high_side_o && low_side_o))
    else $error("both converter gates on");

  chk_charge_qual : assert property (
    charge_en_o |-> s.det_cnt >= QUAL_LIM)
    else $error("charging before qualification delay");

  chk_step_bound : assert property (
    s.step <= STEP_TOP)
    else $error("soft start beyond last step");

  chk_dead_bound : assert property (
    s.dead <= DEAD_LAST)
    else $error("dead time counter overran");

  chk_good_valid : assert property (
    adapter_good_o |-> bias_full_o)
    else $error("adapter good without bias");

  chk_learn_charge : assert property (
    s.sync2.learn |=> !charge_en_o)
    else $error("charging while learn requested");

endmodule : cps_sequencer

// File: bench/cps_fet_model.sv
// Model of the external selector switches behind the two gate drives.
// Assumes drive high means switch on; flags any overlap of conduction.
module cps_fet_model #(
  parameter int ON_DLY = 3  // Turn-on lag in cycles
) (
  input  wire logic clk_i,      // Bench clock
  input  wire logic pack_drv_i, // Pack gate drive
  input  wire logic ad_drv_i,   // Adapter gate drive
  output logic      pack_on_o,  // Pack switch conducting
  output logic      ad_on_o,    // Adapter switch conducting
  output logic      overlap_o   // Both conducted at once
);
  timeunit 1ns;
  timeprecision 1ns;
  int pack_cnt = 0;
  int ad_cnt   = 0;
  initial overlap_o = 1'b0;
  // -------------------------------------------------------------
  // Gates
  // -------------------------------------------------------------
  // Slow turn-on, fast turn-off, so a drive overlap shorter than ON_DLY cycles is not flagged
  always @(posedge clk_i) begin
    pack_cnt = (pack_drv_i === 1'b1) ? pack_cnt + 1 : 0;
    ad_cnt   = (ad_drv_i === 1'b1) ? ad_cnt + 1 : 0;
    if (pack_on_o && ad_on_o) overlap_o <= 1'b1;
  end
  assign pack_on_o = pack_cnt >= ON_DLY;
  assign ad_on_o   = ad_cnt >= ON_DLY;
endmodule : cps_fet_model

// File: bench/tb.sv
// Self-checking bench for the power-path sequencer.
// Assumes the switch model and shortened delay parameters.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cps_pkg::*;
  localparam int DET = 200;
  localparam int INRUSH = 50;
  localparam int STEP = 20;
  localparam logic [12:0] B_SUP = 13'h1000, B_BIAS = 13'h800;
  localparam logic [12:0] B_VAL = 13'h400, B185 = 13'h200, B285 = 13'h100;
  localparam logic [12:0] B_OVP = 13'h080, B_HOT = 13'h040, B_THERM = 13'h020;
  localparam logic [12:0] B_REF = 13'h010, B_CELL = 13'h008;
  localparam logic [12:0] B_BOOT = 13'h004, B_EN = 13'h002, B_LRN = 13'h001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  cps_cmp_s cmp = '0;
  logic req = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = '0, tgt, prog, duty, last;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, q, rnd = 32'h557AB989;
  logic pack, ad, bp, bf, greg, imon, good, chg, hs, ls, off_both;
  logic pk_on, ad_on, ovl;
  logic [12:0] qm [5] = '{B185, B_HOT, B_THERM, B_REF, B_EN};
  int n_errors = 0, cmp_count = 0, n, t;
  assign off_both = !pack && !ad;

  cps_sequencer #(.DETECT_CYC(DET), .INRUSH_CYC(INRUSH), .STEP_CYC(STEP)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pack_gate_drive_o(pack), .adapter_gate_drive_o(ad),
    .bias_partial_o(bp), .bias_full_o(bf), .gate_driver_reg_o(greg),
    .input_current_mon_o(imon), .adapter_good_o(good), .charge_en_o(chg),
    .charge_target_o(tgt), .high_side_o(hs), .low_side_o(ls));
  cps_fet_model #(.ON_DLY(2)) fets (.clk_i(clk_i), .pack_drv_i(pack),
    .ad_drv_i(ad), .pack_on_o(pk_on), .ad_on_o(ad_on), .overlap_o(ovl));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] ramp(input logic [7:0] p, input int k);
    return 8'((int'(p) * k) / SS_STEPS);
  endfunction : ramp
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cyc_n(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc_n
  // Sync plus register latency is three edges; four negedges is the least that covers it
  task automatic flip(input logic [12:0] m, input int w);
    @(posedge clk_i);
    cmp <= cps_cmp_s'(cmp ^ m);
    cyc_n(w);
  endtask : flip
  task automatic wait_for(input string nm, ref logic s, input logic v,
                          input int lim);
    t = 0;
    while (s !== v && t < lim) begin
      @(negedge clk_i);
      t++;
    end
    chk(nm, s, v);
  endtask : wait_for
  task automatic swap(input logic to_ad);
    wait_for("break", off_both, 1'b1, 3000);
    n = 0;
    while (off_both === 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("dead time", n, DEAD_CYC);
    chk("selector", {pack, ad}, {!to_ad, to_ad});
  endtask : swap
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    req <= 1'b0;
    we <= 1'b0;
    chk("bus answer", ack, 1'b1);
  endtask : wb

  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #(100 * 20000);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    rnd = lfsr(rnd);
    prog = 8'h08 + 8'(rnd[7:0] % 8'hF8);
    duty = 8'h01 + {3'b0, rnd[12:8]};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc_n(4);
    chk("dark", {pack, ad, bp, bf, greg, imon, good, chg}, 0);
    flip(B_SUP, 4);
    chk("bias", {pack, ad, bp, bf, imon, greg}, 6'b101000);
    flip(B_BIAS, 4);
    chk("full bias", {bf, imon, greg}, 3'b111);
    flip(B_EN, 4);
    chk("regulator", greg, 1'b0);
    flip(B_EN, 4);
    $display("test bring-up done");
    flip(B_VAL | B185, 0);
    wait_for("good", good, 1'b1, DET + 20);
    chk("detect delay", t >= DET && t <= DET + 8, 1'b1);
    cyc_n(10);
    chk("no headroom", {pack, ad}, 2'b10);
    flip(B285, 0);
    swap(1'b1);
    cyc_n(2 * INRUSH);
    chk("unqualified", chg, 1'b0);
    wb(1'b1, ADR_CTRL, 4'h3, {16'h0, duty, prog});
    wb(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h08, 4'hF, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk("ctrl", q[15:0], {duty, prog});
    flip(B_THERM | B_REF, 0);
    wait_for("charge", chg, 1'b1, 3 * INRUSH);
    last = 8'h00;
    for (int k = 1; k <= 8; k++) begin
      t = 0;
      while (tgt === last && t < 3 * STEP) begin
        @(negedge clk_i);
        t++;
      end
      chk("ramp", tgt, ramp(prog, k));
      if (k > 1) chk("step time", t, STEP);
      last = tgt;
    end
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk("status", q[15:0], {prog, 8'h8B});
    $display("test changeover and soft start done");
    wait_for("pwm low", hs, 1'b0, 40);
    wait_for("pwm high", hs, 1'b1, 40);
    n = 0;
    repeat (PWM_PERIOD) begin
      n += int'(hs === 1'b1 && ls === 1'b0);
      @(negedge clk_i);
    end
    chk("duty", n, duty);
    chk("period", hs, 1'b1);
    wb(1'b1, ADR_CTRL, 4'h3, {16'h0, 8'h21, prog});
    cyc_n(5);
    n = 0;
    repeat (2 * PWM_PERIOD) begin
      n += int'(hs === 1'b1);
      @(negedge clk_i);
    end
    chk("full on", n, 2 * PWM_PERIOD);
    flip(B_BOOT, 4);
    n = 0;
    repeat (2 * PWM_PERIOD) begin
      n += int'(ls === 1'b1);
      @(negedge clk_i);
    end
    chk("early refresh", n, 0);
    wait_for("refresh", ls, 1'b1, 3 * PWM_PERIOD);
    chk("refresh hs", hs, 1'b0);
    cyc_n(1);
    chk("pulse end", {hs, ls}, 2'b10);
    flip(B_BOOT, 4);
    $display("test converter done");
    foreach (qm[i]) begin
      flip(qm[i], 4);
      chk("qualify", chg, 1'b0);
      flip(qm[i], 0);
      wait_for("requalify", chg, 1'b1, 2 * INRUSH + 40);
    end
    flip(B_OVP, 0);
    swap(1'b0);
    chk("ovp charge", chg, 1'b0);
    flip(B_OVP, 0);
    swap(1'b1);
    flip(B_LRN, 0);
    swap(1'b0);
    chk("learn charge", chg, 1'b0);
    flip(B_CELL, 0);
    swap(1'b1);
    chk("learn exit", chg, 1'b0);
    flip(B_CELL, 0);
    swap(1'b0);
    flip(B_LRN, 0);
    swap(1'b1);
    $display("test overrides done");
    flip(B_VAL | B185, 20);
    chk("removal hold", {pack, ad}, 2'b01);
    flip(B285, 0);
    swap(1'b0);
    chk("removed charge", chg, 1'b0);
    chk("overlap", ovl, 1'b0);
    $display("test removal done");
    finish_test();
  end
endmodule : tb
